/* File: rtl/vmc_pkg.sv */
/*
 * package for the vector-magnitude change detector: register indexes,
 * field positions, reset values and widths.
 * assumes a 32-bit classic wishbone slave with one 8-bit register per word.
 */
`default_nettype none
package vmc_pkg;
   // =========================================================
   // widths
   localparam int unsigned VMC_SMP_W  = 14;
   localparam int unsigned VMC_THR_W  = 13;
   localparam int unsigned VMC_CNT_W  = 8;
   localparam int unsigned VMC_SQ_W   = 30;
   localparam int unsigned VMC_IDX_W  = 8;
   localparam int unsigned VMC_AXES   = 3;

   // =========================================================
   // register indexes, byte address is four times the index
   localparam logic [7:0] VMC_IDX_THR_HI   = 8'h60;
   localparam logic [7:0] VMC_IDX_THR_LO   = 8'h61;
   localparam logic [7:0] VMC_IDX_DBN_CNT  = 8'h62;
   localparam logic [7:0] VMC_IDX_REFX_HI  = 8'h63;
   localparam logic [7:0] VMC_IDX_REFX_LO  = 8'h64;
   localparam logic [7:0] VMC_IDX_REFY_HI  = 8'h65;
   localparam logic [7:0] VMC_IDX_REFY_LO  = 8'h66;
   localparam logic [7:0] VMC_IDX_REFZ_HI  = 8'h67;
   localparam logic [7:0] VMC_IDX_REFZ_LO  = 8'h68;
   localparam logic [7:0] VMC_IDX_STATUS   = 8'h69;
   localparam logic [7:0] VMC_IDX_MASK     = 8'h6a;
   localparam logic [7:0] VMC_IDX_LIVE     = 8'h6b;
   localparam logic [7:0] VMC_IDX_CTRL     = 8'h6c;
   localparam logic [7:0] VMC_IDX_DBN_VAL  = 8'h6d;

   // =========================================================
   // field positions
   localparam int unsigned VMC_DBCLR_BIT   = 7;
   localparam int unsigned VMC_THR_HI_W    = 5;
   localparam int unsigned VMC_REF_HI_W    = 6;
   localparam int unsigned VMC_CTRL_EN     = 0;
   localparam int unsigned VMC_CTRL_REFSRC = 1;
   localparam int unsigned VMC_CTRL_HOLD   = 2;
   localparam int unsigned VMC_CTRL_W      = 3;

   // =========================================================
   // reset values
   localparam logic [7:0] VMC_RST_THR_HI  = 8'h00;
   localparam logic [7:0] VMC_RST_THR_LO  = 8'h00;
   localparam logic [7:0] VMC_RST_DBN     = 8'h00;
   localparam logic [5:0] VMC_RST_REF_HI  = 6'h00;
   localparam logic [7:0] VMC_RST_REF_LO  = 8'h00;
   localparam logic [2:0] VMC_RST_CTRL    = 3'h0;
endpackage
`default_nettype wire

/* File: rtl/vmc_mag_if.sv */
/*
 * interface carrying the per-axis differences and threshold to the
 * magnitude comparator and its one-cycle-late verdict back.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface vmc_mag_if;
   import vmc_pkg::*;
   logic signed [VMC_SMP_W:0]   diff [0:VMC_AXES-1];
   logic        [VMC_THR_W-1:0] thr;
   logic                        strobe;
   logic                        above;
   logic                        done;

   modport src  (output diff, output thr, output strobe, input above, input done);
   modport calc (input diff, input thr, input strobe, output above, output done);
endinterface
`default_nettype wire

/* File: rtl/vmc_mag_cmp.sv */
/*
 * squared euclidean magnitude of the reference differences against the
 * squared threshold; result is registered one cycle after the strobe.
 * assumes differences fit 15 bits signed (14-bit sample minus 14-bit ref).
 */
`timescale 1ns/1ps
`default_nettype none
module vmc_mag_cmp
   import vmc_pkg::*;
(
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // comparator side
   vmc_mag_if.calc   mag
);
   logic [VMC_SMP_W-1:0] abs_v [0:VMC_AXES-1];
   logic [VMC_SQ_W-1:0]  sum_sq;
   logic [VMC_SQ_W-1:0]  thr_sq;
   logic                 above_reg;
   logic                 above_next;
   logic                 done_reg;
   logic                 done_next;

   genvar g;
   generate
      for (g = 0; g < VMC_AXES; g++)
      begin : g_abs
         assign abs_v[g] = mag.diff[g][VMC_SMP_W] ? VMC_SMP_W'(-mag.diff[g]) : mag.diff[g][VMC_SMP_W-1:0];
      end
   endgenerate

   always_comb
   begin
      // widen before the product so the squares keep every bit
      sum_sq     = VMC_SQ_W'(abs_v[0]) * VMC_SQ_W'(abs_v[0]) + VMC_SQ_W'(abs_v[1]) * VMC_SQ_W'(abs_v[1])
                 + VMC_SQ_W'(abs_v[2]) * VMC_SQ_W'(abs_v[2]);
      thr_sq     = VMC_SQ_W'(mag.thr) * VMC_SQ_W'(mag.thr);
      // sqrt(sum) > thr is the same as sum > thr squared
      above_next = mag.strobe ? (sum_sq > thr_sq) : above_reg; // [R10]
      done_next  = mag.strobe;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         above_reg <= 1'b0;
         done_reg  <= 1'b0;
      end
      else
      begin
         above_reg <= above_next;
         done_reg  <= done_next;
      end
   end

   assign mag.above = above_reg;
   assign mag.done  = done_reg;
endmodule
`default_nettype wire

/* File: rtl/vmc_debounce.sv */
/*
 * debounce counter and live change flag, stepped once per sample.
 * assumes i_tick is a one-cycle pulse per judged sample, same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module vmc_debounce
   import vmc_pkg::*;
#(
   parameter int unsigned CNT_W = VMC_CNT_W
)
(
   // clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   // control
   input  wire logic             i_enable,
   input  wire logic             i_clr_mode,
   input  wire logic [CNT_W-1:0] i_limit,
   // per-sample verdict
   input  wire logic             i_tick,
   input  wire logic             i_above,
   // state
   output logic      [CNT_W-1:0] o_count,
   output logic                  o_flag
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic             flag_reg;
   logic             flag_next;

   always_comb
   begin
      cnt_next  = cnt_reg;
      flag_next = flag_reg;
      if (!i_enable)
      begin
         cnt_next  = '0;
         flag_next = 1'b0;
      end
      else if (i_tick)
      begin
         if (i_above)
         begin
            // flag once above for longer than the programmed count
            flag_next = (cnt_reg >= i_limit); // [R10] [R5]
            if (cnt_reg < i_limit)
               cnt_next = cnt_reg + CNT_W'(1); // [R13]
            else
               cnt_next = i_limit; // [R13]
         end
         else
         begin
            flag_next = 1'b0;
            if (i_clr_mode)
               cnt_next = '0; // [R2]
            else if (cnt_reg != '0)
               cnt_next = cnt_reg - CNT_W'(1); // [R1]
         end
      end
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         cnt_reg  <= '0;
         flag_reg <= 1'b0;
      end
      else
      begin
         cnt_reg  <= cnt_next;
         flag_reg <= flag_next;
      end
   end

   assign o_count = cnt_reg;
   assign o_flag  = flag_reg;
endmodule
`default_nettype wire

/* File: rtl/vmc_top.sv */
/*
 * vector-magnitude change detector: wishbone register file, reference
 * handling, magnitude comparator and debounce, sticky event and interrupt.
 * assumes samples and their valid pulse come from logic on i_ref_clk,
 * one valid pulse per output-data-rate interval, already at the selected
 * full-scale range.
 */
// The Wishbone slave port was decided locally.
// Functional notes
// R1 - with the clear-mode bit at 0, a sample below threshold steps the debounce counter down by one.
// R2 - with the clear-mode bit at 1, a sample below threshold clears the debounce counter at once.
// R3 - the threshold is 13 bits unsigned, top five bits at 0x60 under the clear-mode bit, low eight at 0x61.
// R4 - one threshold count equals one sample count at the current full-scale range.
// R5 - the debounce period is the 8-bit count at 0x62 times one sample interval.
// R6 - the X initial reference is 14 bits signed, six at 0x63 and eight at 0x64, used when the source bit is set.
// R7 - the Y initial reference is 14 bits signed, six at 0x65 and eight at 0x66, used when the source bit is set.
// R8 - the Z initial reference is 14 bits signed, six at 0x67 and eight at 0x68, used when the source bit is set.
// R9 - initial references are in the same units as the samples.
// R10 - the change flag rises when the difference magnitude stays above threshold longer than the count.
// R11 - on enable, references load from the initial registers with the source bit at 1, else from current samples.
// R12 - with source and hold bits both set, host writes to the initial registers act as live references.
// R13 - the debounce counter climbs by one per sample above threshold and saturates at the count.
`timescale 1ns/1ps
`default_nettype none
module vmc_top
   import vmc_pkg::*;
#(
   parameter int unsigned ADR_W = 10
)
(
   // clock and reset
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst_n,
   // wishbone slave
   input  wire logic                 i_wb_cyc,
   input  wire logic                 i_wb_stb,
   input  wire logic                 i_wb_we,
   input  wire logic [ADR_W-1:0]     i_wb_adr,
   input  wire logic [3:0]           i_wb_sel,
   input  wire logic [31:0]          i_wb_dat,
   output logic      [31:0]          o_wb_dat,
   output logic                      o_wb_ack,
   // acceleration samples
   input  wire logic                 i_sample_valid,
   input  wire logic [VMC_SMP_W-1:0] i_sample_x,
   input  wire logic [VMC_SMP_W-1:0] i_sample_y,
   input  wire logic [VMC_SMP_W-1:0] i_sample_z,
   // event outputs
   output logic                      o_change_flag,
   output logic                      o_irq
);
   // =========================================================
   // declarations
   vmc_mag_if mag ();

   logic [7:0]           thr_hi_reg,  thr_hi_next;
   logic [7:0]           thr_lo_reg,  thr_lo_next;
   logic [7:0]           dbn_reg,     dbn_next;
   logic [5:0]           ini_hi_reg   [0:VMC_AXES-1];
   logic [5:0]           ini_hi_next  [0:VMC_AXES-1];
   logic [7:0]           ini_lo_reg   [0:VMC_AXES-1];
   logic [7:0]           ini_lo_next  [0:VMC_AXES-1];
   logic [VMC_SMP_W-1:0] ref_reg      [0:VMC_AXES-1];
   logic [VMC_SMP_W-1:0] ref_next     [0:VMC_AXES-1];
   logic [VMC_SMP_W-1:0] last_reg     [0:VMC_AXES-1];
   logic [VMC_SMP_W-1:0] last_next    [0:VMC_AXES-1];
   logic [VMC_SMP_W-1:0] smp          [0:VMC_AXES-1];
   logic [VMC_SMP_W-1:0] ini_val      [0:VMC_AXES-1];
   logic [VMC_CTRL_W-1:0] ctrl_reg,   ctrl_next;
   logic                 status_reg,  status_next;
   logic                 mask_reg,    mask_next;
   logic                 irq_reg,     irq_next;
   logic                 ack_reg,     ack_next;
   logic [31:0]          dat_reg,     dat_next;
   logic                 en_d_reg,    en_d_next;
   logic                 flag_d_reg,  flag_d_next;
   logic [VMC_IDX_W-1:0] idx;
   logic                 req;
   logic                 wr;
   logic [7:0]           wd;
   logic                 flag;
   logic [VMC_CNT_W-1:0] dbn_val;
   logic                 en;
   logic                 en_rise;
   logic                 ev_rise;
   logic                 live_ref;

   assign smp[0] = i_sample_x;
   assign smp[1] = i_sample_y;
   assign smp[2] = i_sample_z;

   assign idx = i_wb_adr[VMC_IDX_W+1:2];
   assign req = i_wb_cyc && i_wb_stb && !ack_reg;
   assign wr  = req && i_wb_we && i_wb_sel[0];
   assign wd  = i_wb_dat[7:0];

   assign en       = ctrl_reg[VMC_CTRL_EN];
   assign en_rise  = en && !en_d_reg;
   assign ev_rise  = flag && !flag_d_reg;
   assign live_ref = ctrl_reg[VMC_CTRL_REFSRC] && ctrl_reg[VMC_CTRL_HOLD];

   // =========================================================
   // initial reference assembly, signed 14 bits per axis
   genvar g;
   generate
      for (g = 0; g < VMC_AXES; g++)
      begin : g_axis
         assign ini_val[g]  = {ini_hi_reg[g], ini_lo_reg[g]}; // [R6] [R7] [R8]
         // same units as the samples, so no rescale is applied
         assign mag.diff[g] = $signed({smp[g][VMC_SMP_W-1], smp[g]})
                            - $signed({ref_reg[g][VMC_SMP_W-1], ref_reg[g]}); // [R9]
      end
   endgenerate

   // threshold compared in sample counts at the current range
   assign mag.thr    = {thr_hi_reg[VMC_THR_HI_W-1:0], thr_lo_reg}; // [R3] [R4]
   assign mag.strobe = i_sample_valid && en && !en_rise;

   // =========================================================
   // magnitude and debounce
   vmc_mag_cmp u_mag (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .mag       (mag)
   );

   vmc_debounce #(
      .CNT_W (VMC_CNT_W)
   ) u_dbn (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_enable   (en),
      .i_clr_mode (thr_hi_reg[VMC_DBCLR_BIT]), // [R1] [R2]
      .i_limit    (dbn_reg), // [R5]
      .i_tick     (mag.done),
      .i_above    (mag.above),
      .o_count    (dbn_val),
      .o_flag     (flag)
   );

   // =========================================================
   // register writes
   always_comb
   begin
      thr_hi_next = thr_hi_reg;
      thr_lo_next = thr_lo_reg;
      dbn_next    = dbn_reg;
      ctrl_next   = ctrl_reg;
      mask_next   = mask_reg;
      for (int i = 0; i < VMC_AXES; i++)
      begin
         ini_hi_next[i] = ini_hi_reg[i];
         ini_lo_next[i] = ini_lo_reg[i];
      end
      if (wr)
      begin
         if (idx == VMC_IDX_THR_HI)
            thr_hi_next = wd & 8'h9f; // [R3]
         else if (idx == VMC_IDX_THR_LO)
            thr_lo_next = wd; // [R3]
         else if (idx == VMC_IDX_DBN_CNT)
            dbn_next = wd; // [R5]
         else if (idx == VMC_IDX_REFX_HI)
            ini_hi_next[0] = wd[5:0]; // [R6]
         else if (idx == VMC_IDX_REFX_LO)
            ini_lo_next[0] = wd; // [R6]
         else if (idx == VMC_IDX_REFY_HI)
            ini_hi_next[1] = wd[5:0]; // [R7]
         else if (idx == VMC_IDX_REFY_LO)
            ini_lo_next[1] = wd; // [R7]
         else if (idx == VMC_IDX_REFZ_HI)
            ini_hi_next[2] = wd[5:0]; // [R8]
         else if (idx == VMC_IDX_REFZ_LO)
            ini_lo_next[2] = wd; // [R8]
         else if (idx == VMC_IDX_MASK)
            mask_next = wd[0];
         else if (idx == VMC_IDX_CTRL)
            ctrl_next = wd[VMC_CTRL_W-1:0];
      end
   end

   // =========================================================
   // references, sticky status, interrupt
   always_comb
   begin
      en_d_next   = en;
      flag_d_next = flag;
      for (int i = 0; i < VMC_AXES; i++)
      begin
         last_next[i] = i_sample_valid ? smp[i] : last_reg[i];
         ref_next[i]  = ref_reg[i];
         if (live_ref)
            ref_next[i] = ini_val[i]; // [R12]
         else if (en_rise)
            ref_next[i] = ctrl_reg[VMC_CTRL_REFSRC] ? ini_val[i] : last_reg[i]; // [R11]
         else if (ev_rise && !ctrl_reg[VMC_CTRL_HOLD])
            ref_next[i] = last_reg[i];
      end
      // set wins over a write-one-to-clear in the same cycle
      status_next = status_reg;
      if (wr && idx == VMC_IDX_STATUS && wd[0])
         status_next = 1'b0;
      if (ev_rise)
         status_next = 1'b1; // [R10]
      irq_next = status_next && mask_next;
   end

   // =========================================================
   // bus answer, one cycle after the request, unmapped reads zero
   always_comb
   begin
      ack_next = req;
      dat_next = 32'h0000_0000;
      if (req && !i_wb_we)
      begin
         if (idx == VMC_IDX_THR_HI)
            dat_next[7:0] = thr_hi_reg;
         else if (idx == VMC_IDX_THR_LO)
            dat_next[7:0] = thr_lo_reg;
         else if (idx == VMC_IDX_DBN_CNT)
            dat_next[7:0] = dbn_reg;
         else if (idx == VMC_IDX_REFX_HI)
            dat_next[5:0] = ini_hi_reg[0];
         else if (idx == VMC_IDX_REFX_LO)
            dat_next[7:0] = ini_lo_reg[0];
         else if (idx == VMC_IDX_REFY_HI)
            dat_next[5:0] = ini_hi_reg[1];
         else if (idx == VMC_IDX_REFY_LO)
            dat_next[7:0] = ini_lo_reg[1];
         else if (idx == VMC_IDX_REFZ_HI)
            dat_next[5:0] = ini_hi_reg[2];
         else if (idx == VMC_IDX_REFZ_LO)
            dat_next[7:0] = ini_lo_reg[2];
         else if (idx == VMC_IDX_STATUS)
            dat_next[0] = status_reg;
         else if (idx == VMC_IDX_MASK)
            dat_next[0] = mask_reg;
         else if (idx == VMC_IDX_LIVE)
            dat_next[0] = flag;
         else if (idx == VMC_IDX_CTRL)
            dat_next[VMC_CTRL_W-1:0] = ctrl_reg;
         else if (idx == VMC_IDX_DBN_VAL)
            dat_next[7:0] = dbn_val;
      end
   end

   // =========================================================
   // state registers
   always_ff @(posedge i_ref_clk)
   begin
      if (!i_rst_n)
      begin
         thr_hi_reg <= VMC_RST_THR_HI;
         thr_lo_reg <= VMC_RST_THR_LO;
         dbn_reg    <= VMC_RST_DBN;
         ctrl_reg   <= VMC_RST_CTRL;
         mask_reg   <= 1'b0;
         status_reg <= 1'b0;
         irq_reg    <= 1'b0;
         ack_reg    <= 1'b0;
         dat_reg    <= 32'h0000_0000;
         en_d_reg   <= 1'b0;
         flag_d_reg <= 1'b0;
         for (int i = 0; i < VMC_AXES; i++)
         begin
            ini_hi_reg[i] <= VMC_RST_REF_HI;
            ini_lo_reg[i] <= VMC_RST_REF_LO;
            ref_reg[i]    <= '0;
            last_reg[i]   <= '0;
         end
      end
      else
      begin
         thr_hi_reg <= thr_hi_next;
         thr_lo_reg <= thr_lo_next;
         dbn_reg    <= dbn_next;
         ctrl_reg   <= ctrl_next;
         mask_reg   <= mask_next;
         status_reg <= status_next;
         irq_reg    <= irq_next;
         ack_reg    <= ack_next;
         dat_reg    <= dat_next;
         en_d_reg   <= en_d_next;
         flag_d_reg <= flag_d_next;
         for (int i = 0; i < VMC_AXES; i++)
         begin
            ini_hi_reg[i] <= ini_hi_next[i];
            ini_lo_reg[i] <= ini_lo_next[i];
            ref_reg[i]    <= ref_next[i];
            last_reg[i]   <= last_next[i];
         end
      end
   end

   assign o_wb_ack      = ack_reg;
   assign o_wb_dat      = dat_reg;
   assign o_irq         = irq_reg;
   assign o_change_flag = flag;
endmodule
`default_nettype wire

/* File: verification/vmc_top_sva.sv */
/*
 * checker for vmc_top: bus handshake, read data, flag and irq causes.
 * assumes it sees only the top ports, bound into every vmc_top.
 */
`timescale 1ns/1ps
`default_nettype none
module vmc_top_sva
   import vmc_pkg::*;
#(
   parameter int unsigned ADR_W = 10
)
(
   // clock and reset
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst_n,
   // wishbone slave
   input  wire logic                 i_wb_cyc,
   input  wire logic                 i_wb_stb,
   input  wire logic                 i_wb_we,
   input  wire logic [ADR_W-1:0]     i_wb_adr,
   input  wire logic [3:0]           i_wb_sel,
   input  wire logic [31:0]          i_wb_dat,
   input  wire logic [31:0]          o_wb_dat,
   input  wire logic                 o_wb_ack,
   // samples and events
   input  wire logic                 i_sample_valid,
   input  wire logic [VMC_SMP_W-1:0] i_sample_x,
   input  wire logic [VMC_SMP_W-1:0] i_sample_y,
   input  wire logic [VMC_SMP_W-1:0] i_sample_z,
   input  wire logic                 o_change_flag,
   input  wire logic                 o_irq
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   // =========================================================
   // sequences
   sequence wb_req_s;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence quiet_s;
      !i_sample_valid && !(i_wb_cyc && i_wb_we);
   endsequence

   // =========================================================
   // assertions
   ack_latency_a: assert property (wb_req_s |=> o_wb_ack)
      else $error("ack missing one cycle after request");
   ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb))
      else $error("ack without request");
   rdata_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data outside ack");
   rdata_upper_a: assert property (o_wb_dat[31:8] == 24'h0)
      else $error("read data upper bits set");
   flag_cause_a: assert property ($rose(o_change_flag) |-> $past(i_sample_valid, 2))
      else $error("flag rose without sample");
   flag_quiet_a: assert property (quiet_s [*4] |=> $stable(o_change_flag))
      else $error("flag moved without cause");
   irq_quiet_a: assert property (quiet_s [*5] |=> $stable(o_irq))
      else $error("irq moved without cause");
   reset_quiet_a: assert property (disable iff (1'b0)
      !i_rst_n |=> !o_wb_ack && !o_irq && !o_change_flag && o_wb_dat == 32'h0)
      else $error("outputs active after reset");
endmodule

bind vmc_top vmc_top_sva #(.ADR_W(ADR_W)) u_sva (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
   .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
   .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sample_valid(i_sample_valid),
   .i_sample_x(i_sample_x), .i_sample_y(i_sample_y), .i_sample_z(i_sample_z),
   .o_change_flag(o_change_flag), .o_irq(o_irq));
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 * testbench for vmc_top: registers over wishbone, debounce, refs, irq.
 * assumes the checker is bound in; samples driven directly by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vmc_pkg::*;
   // =========================================================
   // signals
   logic        i_ref_clk      = 1'b0;
   logic        i_rst_n        = 1'b0;
   logic        i_wb_cyc       = 1'b0;
   logic        i_wb_stb       = 1'b0;
   logic        i_wb_we        = 1'b0;
   logic [9:0]  i_wb_adr       = 10'h0;
   logic [3:0]  i_wb_sel       = 4'h0;
   logic [31:0] i_wb_dat       = 32'h0;
   logic        i_sample_valid = 1'b0;
   logic [13:0] i_sample_x     = 14'h0;
   logic [13:0] i_sample_y     = 14'h0;
   logic [13:0] i_sample_z     = 14'h0;
   logic [31:0] o_wb_dat;
   logic        o_wb_ack;
   logic        o_change_flag;
   logic        o_irq;
   logic [31:0] rd;
   int          error_cnt      = 0;
   int          n_tests        = 0;

   vmc_top #(.ADR_W(10)) uut (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
      .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_sample_valid(i_sample_valid),
      .i_sample_x(i_sample_x), .i_sample_y(i_sample_y), .i_sample_z(i_sample_z),
      .o_change_flag(o_change_flag), .o_irq(o_irq));

   initial
   begin
      forever #5 i_ref_clk = ~i_ref_clk;
   end

   // =========================================================
   // tasks
   task automatic finish_test;
      $display("TB: errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wb_xfer(input logic [7:0] idx, input logic we, input logic [7:0] wd);
      int n;
      @(posedge i_ref_clk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we  <= we;
      i_wb_adr <= {idx, 2'b00};
      i_wb_sel <= 4'h1;
      i_wb_dat <= {24'h0, wd};
      n = 0;
      do
      begin
         @(posedge i_ref_clk);
         n++;
      end while (o_wb_ack !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         check("bus_ack", {31'h0, o_wb_ack}, 32'h1);
         finish_test;
      end
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we  <= 1'b0;
   endtask

   task automatic wb_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
      wb_xfer(idx, 1'b0, 8'h00);
      check(name, rd, exp);
   endtask

   // one sample at offsets from the base point (-3, 5, -7), then counter and flag
   task automatic step(input int dx, input int dy, input int dz, input int cnt, input logic flag);
      @(posedge i_ref_clk);
      i_sample_valid <= 1'b1;
      i_sample_x     <= 14'(-3 + dx);
      i_sample_y     <= 14'(5 + dy);
      i_sample_z     <= 14'(-7 + dz);
      @(posedge i_ref_clk);
      i_sample_valid <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
      check("change_flag", {31'h0, o_change_flag}, {31'h0, flag});
      wb_chk("debounce_value", VMC_IDX_DBN_VAL, 32'(cnt));
      wb_chk("live_flag", VMC_IDX_LIVE, {31'h0, flag});
   endtask

   // =========================================================
   // main sequence
   initial
   begin
      repeat (12) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      @(posedge i_ref_clk);
      for (int i = 8'h60; i <= 8'h6d; i++)
         wb_chk("reset_value", 8'(i), 32'h0);
      for (int i = 8'h60; i <= 8'h68; i++)
      begin
         wb_xfer(8'(i), 1'b1, 8'hff);
         wb_chk("rw_value", 8'(i), (i == 8'h60) ? 32'h9f : (i[0] && i != 8'h61) ? 32'h3f : 32'hff);
      end
      wb_xfer(8'h10, 1'b1, 8'hff);
      wb_chk("unmapped", 8'h10, 32'h0);
      $display("TB: register test done");
      // threshold 10, count 2, refs x=-3 y=5 z=-7
      wb_xfer(VMC_IDX_THR_HI, 1'b1, 8'h00);
      wb_xfer(VMC_IDX_THR_LO, 1'b1, 8'h0a);
      wb_xfer(VMC_IDX_DBN_CNT, 1'b1, 8'h02);
      wb_xfer(VMC_IDX_REFX_HI, 1'b1, 8'h3f);
      wb_xfer(VMC_IDX_REFX_LO, 1'b1, 8'hfd);
      wb_xfer(VMC_IDX_REFY_HI, 1'b1, 8'h00);
      wb_xfer(VMC_IDX_REFY_LO, 1'b1, 8'h05);
      wb_xfer(VMC_IDX_REFZ_HI, 1'b1, 8'h3f);
      wb_xfer(VMC_IDX_REFZ_LO, 1'b1, 8'hf9);
      wb_xfer(VMC_IDX_MASK, 1'b1, 8'h00);
      wb_xfer(VMC_IDX_CTRL, 1'b1, 8'h07);
      step(11, 0, 0, 1, 1'b0);
      step(0, 11, 0, 2, 1'b0);
      step(0, 0, 11, 2, 1'b1);
      wb_chk("status", VMC_IDX_STATUS, 32'h1);
      check("irq_masked", {31'h0, o_irq}, 32'h0);
      wb_xfer(VMC_IDX_MASK, 1'b1, 8'h01);
      wb_chk("mask", VMC_IDX_MASK, 32'h1);
      check("irq_unmasked", {31'h0, o_irq}, 32'h1);
      step(10, 0, 0, 1, 1'b0);
      wb_xfer(VMC_IDX_STATUS, 1'b1, 8'h01);
      wb_chk("status_clr", VMC_IDX_STATUS, 32'h0);
      check("irq_cleared", {31'h0, o_irq}, 32'h0);
      $display("TB: debounce decrement test done");
      wb_xfer(VMC_IDX_THR_HI, 1'b1, 8'h80);
      step(11, 0, 0, 2, 1'b0);
      step(0, 0, 0, 0, 1'b0);
      // live reference x moves to 17 while running
      wb_xfer(VMC_IDX_REFX_HI, 1'b1, 8'h00);
      wb_xfer(VMC_IDX_REFX_LO, 1'b1, 8'h11);
      step(0, 0, 0, 1, 1'b0);
      $display("TB: clear mode and live reference test done");
      wb_xfer(VMC_IDX_CTRL, 1'b1, 8'h00);
      step(0, 0, 0, 0, 1'b0);
      wb_xfer(VMC_IDX_CTRL, 1'b1, 8'h01);
      step(0, 0, 0, 0, 1'b0);
      step(0, 0, 11, 1, 1'b0);
      $display("TB: sample reference test done");
      wb_xfer(VMC_IDX_CTRL, 1'b1, 8'h00);
      wb_xfer(VMC_IDX_CTRL, 1'b1, 8'h03);
      // refs now loaded once from the initial registers (17, 5, -7)
      step(20, 0, 0, 0, 1'b0);
      step(0, 0, 0, 1, 1'b0);
      step(0, 0, 0, 2, 1'b0);
      step(0, 0, 0, 2, 1'b1);
      // flag rising with hold clear reloads refs from the last sample
      step(0, 0, 0, 0, 1'b0);
      $display("TB: reference reload test done");
      finish_test;
   end
endmodule
`default_nettype wire
